// ===== src/sdcr_core.sv
// SDRAM command decode, bank state and read burst core
module sdcr_core #(
    parameter int CAS_LAT = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Command pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [sdcr_pkg::BANK_W-1:0] bank,
    input wire logic [sdcr_pkg::ROW_W-1:0] addr,
    input wire logic [sdcr_pkg::MASK_W-1:0] dqm,
    // Mode settings
    input wire logic [2:0] burst_len,
    input wire logic burst_interleave,
    input wire logic [sdcr_pkg::LAT_W-1:0] cas_latency,
    // Array read data
    input wire logic [sdcr_pkg::DQ_W-1:0] array_rdata,
    // Data pins
    output logic [sdcr_pkg::DQ_W-1:0] dq_o,
    output logic [sdcr_pkg::DQ_W-1:0] dq_oe,
    // Array read request
    output logic array_rd,
    output logic [sdcr_pkg::BANK_W-1:0] array_bank,
    output logic [sdcr_pkg::ROW_W-1:0] array_row,
    output logic [sdcr_pkg::COL_W-1:0] array_col,
    // Status
    output logic [sdcr_pkg::BANKS-1:0] bank_open,
    output logic illegal_access,
    output logic auto_close_req,
    output logic [1:0] power_state
);
    localparam int PIPE = 8;

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [sdcr_pkg::BANKS-1:0] open;
        logic [sdcr_pkg::BANKS-1:0][sdcr_pkg::ROW_W-1:0] row;
        logic active;
        logic [sdcr_pkg::BANK_W-1:0] rbank;
        logic [sdcr_pkg::COL_W-1:0] start_col;
        logic [sdcr_pkg::COL_W:0] step;
        logic [PIPE-1:0] vld_pipe;
        logic [sdcr_pkg::MASK_LAT-1:0][sdcr_pkg::MASK_W-1:0] mask_pipe;
        logic [sdcr_pkg::MASK_W-1:0] mask_late;
        logic [sdcr_pkg::DQ_W-1:0] rdata;
        sdcr_pkg::sdcr_pwr_type pwr;
        logic [sdcr_pkg::DQ_W-1:0] dq_o;
        logic [sdcr_pkg::DQ_W-1:0] dq_oe;
        logic rd;
        logic [sdcr_pkg::BANK_W-1:0] abank;
        logic [sdcr_pkg::ROW_W-1:0] arow;
        logic [sdcr_pkg::COL_W-1:0] acol;
        logic illegal;
        logic auto_close;
    } sdcr_core_state_type;

    sdcr_core_state_type s_q, s_d;
    sdcr_cmd_if cmd_if ();

    sdcr_decode u_decode (
        .clk(clk),
        .rst_n(s_q.rst_sync[1]),
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .cke(cke),
        .bank(bank),
        .addr(addr),
        .mask(dqm),
        .out(cmd_if.producer)
    );

    // ****************************************************
    // Burst helpers
    // ****************************************************
    function automatic logic [sdcr_pkg::COL_W:0] burst_words(
        input logic [2:0] bl);
        case (bl)
            sdcr_pkg::BL_1: burst_words = 9'h001;
            sdcr_pkg::BL_2: burst_words = 9'h002;
            sdcr_pkg::BL_4: burst_words = 9'h004;
            sdcr_pkg::BL_8: burst_words = 9'h008;
            default: burst_words = 9'h000;
        endcase
    endfunction

    function automatic logic [sdcr_pkg::COL_W-1:0] burst_col(
        input logic [sdcr_pkg::COL_W-1:0] start,
        input logic [sdcr_pkg::COL_W:0] n,
        input logic [2:0] bl,
        input logic ilv);
        logic [sdcr_pkg::COL_W-1:0] wrap, k;
        wrap = sdcr_pkg::COL_W'(burst_words(bl) - sdcr_pkg::CNT_ONE);
        k = n[sdcr_pkg::COL_W-1:0];
        if (bl == sdcr_pkg::BL_PAGE) begin
            burst_col = start + k;
        end else if (ilv) begin
            burst_col = (start & ~wrap) | ((start ^ k) & wrap);
        end else begin
            burst_col = (start & ~wrap) | ((start + k) & wrap);
        end
    endfunction

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        logic [sdcr_pkg::BANK_W-1:0] b;
        logic last;
        logic lat_hit;
        logic [sdcr_pkg::MASK_W-1:0] m;
        b = cmd_if.bank;
        last = (burst_len != sdcr_pkg::BL_PAGE) &&
            (s_q.step + sdcr_pkg::CNT_ONE >= burst_words(burst_len));
        lat_hit = s_q.vld_pipe[cas_latency - 3'h1];
        m = s_q.mask_late;
        s_d = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        s_d.illegal = 1'b0;
        s_d.auto_close = 1'b0;
        s_d.rd = 1'b0;
        s_d.mask_pipe[0] = cmd_if.mask;
        s_d.mask_pipe[1] = s_q.mask_pipe[0];
        // Extra stage covers the array read cycle
        s_d.mask_late = s_q.mask_pipe[sdcr_pkg::MASK_LAT-1];
        if (s_q.pwr == sdcr_pkg::PWR_RUN && !cmd_if.cke_now) begin
            s_d.pwr = s_q.active ? sdcr_pkg::PWR_SUSPEND
                : sdcr_pkg::PWR_DOWN;
        end else if (s_q.pwr != sdcr_pkg::PWR_RUN && cmd_if.cke_now) begin
            s_d.pwr = sdcr_pkg::PWR_RUN;
        end
        s_d.vld_pipe = {s_q.vld_pipe[PIPE-2:0], 1'b0};
        if (s_q.active && s_q.pwr != sdcr_pkg::PWR_SUSPEND) begin
            s_d.rd = 1'b1;
            s_d.abank = s_q.rbank;
            s_d.arow = s_q.row[s_q.rbank];
            s_d.acol = burst_col(s_q.start_col, s_q.step, burst_len,
                burst_interleave);
            s_d.vld_pipe[0] = 1'b1;
            s_d.step = s_q.step + sdcr_pkg::CNT_ONE;
            if (last) begin
                s_d.active = 1'b0;
            end
        end
        case (cmd_if.cmd)
            sdcr_pkg::DEC_OPEN: begin
                if (!s_q.open[b]) begin
                    s_d.open[b] = 1'b1;
                    s_d.row[b] = cmd_if.addr;
                end
            end
            sdcr_pkg::DEC_CLOSE: begin
                s_d.open[b] = 1'b0;
                if (s_q.active && s_q.rbank == b) begin
                    s_d.active = 1'b0;
                end
            end
            sdcr_pkg::DEC_CLOSE_ALL: begin
                s_d.open = '0;
                s_d.active = 1'b0;
            end
            sdcr_pkg::DEC_READ, sdcr_pkg::DEC_WRITE: begin
                s_d.active = 1'b0;
                if (!s_q.open[b]) begin
                    s_d.illegal = 1'b1;
                end else if (cmd_if.cmd == sdcr_pkg::DEC_READ) begin
                    s_d.active = 1'b1;
                    s_d.rbank = b;
                    s_d.start_col = cmd_if.addr[sdcr_pkg::COL_W-1:0];
                    s_d.step = sdcr_pkg::CNT_ZERO;
                    s_d.auto_close =
                        cmd_if.addr[sdcr_pkg::AUTO_CLOSE_BIT];
                end
            end
            sdcr_pkg::DEC_STOP: s_d.active = 1'b0;
            sdcr_pkg::DEC_REFRESH: begin
                if (!cmd_if.cke_now) begin
                    s_d.pwr = sdcr_pkg::PWR_SELF;
                end
            end
            default: ;
        endcase
        if (cmd_if.cmd == sdcr_pkg::DEC_WRITE) begin
            s_d.vld_pipe = '0;
        end
        if (!s_d.open[s_q.rbank]) begin
            s_d.rd = 1'b0;
            s_d.vld_pipe[0] = 1'b0;
        end
        s_d.rdata = array_rdata;
        s_d.dq_o = (cas_latency > sdcr_pkg::LAT_W'(CAS_LAT)) ?
            s_q.rdata : array_rdata;
        s_d.dq_oe = '0;
        if (lat_hit) begin
            s_d.dq_oe = {{8{~m[1]}}, {8{~m[0]}}};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dq_o = s_q.dq_o;
    assign dq_oe = s_q.dq_oe;
    assign array_rd = s_q.rd;
    assign array_bank = s_q.abank;
    assign array_row = s_q.arow;
    assign array_col = s_q.acol;
    assign bank_open = s_q.open;
    assign illegal_access = s_q.illegal;
    assign auto_close_req = s_q.auto_close;
    assign power_state = s_q.pwr;
endmodule // sdcr_core

// ===== shared/sdcr_pkg.sv
// Package of constants and types for the SDRAM command, bank and read core
package sdcr_pkg;
    // ****************************************************
    // Geometry
    // ****************************************************
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int ROW_W = 12;
    localparam int COL_W = 8;
    localparam int DQ_W = 16;
    localparam int MASK_W = 2;
    localparam int AUTO_CLOSE_BIT = 10;
    localparam int MASK_LAT = 2;
    localparam int SYNC_STAGES = 3;
    localparam int LAT_W = 3;

    // ****************************************************
    // Burst length codes
    // ****************************************************
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [COL_W-1:0] COL_ONE = 8'h01;
    localparam logic [COL_W:0] CNT_ONE = 9'h001;
    localparam logic [COL_W:0] CNT_ZERO = 9'h000;

    // ****************************************************
    // Command codes {ras_n, cas_n, we_n}
    // ****************************************************
    localparam logic [2:0] CMD_OPEN = 3'h3;
    localparam logic [2:0] CMD_CLOSE = 3'h2;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_STOP = 3'h6;
    localparam logic [2:0] CMD_REFRESH = 3'h1;

    typedef enum logic [2:0] {
        DEC_NONE, DEC_OPEN, DEC_CLOSE, DEC_CLOSE_ALL,
        DEC_READ, DEC_WRITE, DEC_STOP, DEC_REFRESH
    } sdcr_cmd_type;

    typedef enum logic [1:0] {
        PWR_RUN, PWR_SUSPEND, PWR_DOWN, PWR_SELF
    } sdcr_pwr_type;
endpackage

// ===== shared/sdcr_cmd_if.sv
// Interface carrying a decoded command from decoder to core
interface sdcr_cmd_if;
    sdcr_pkg::sdcr_cmd_type cmd;
    logic [sdcr_pkg::BANK_W-1:0] bank;
    logic [sdcr_pkg::ROW_W-1:0] addr;
    logic cke_now;
    logic [sdcr_pkg::MASK_W-1:0] mask;
    modport producer (output cmd, bank, addr, cke_now, mask);
    modport consumer (input cmd, bank, addr, cke_now, mask);
endinterface

// ===== src/sdcr_decode.sv
// Command input synchroniser and decoder
module sdcr_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [sdcr_pkg::BANK_W-1:0] bank,
    input wire logic [sdcr_pkg::ROW_W-1:0] addr,
    input wire logic [sdcr_pkg::MASK_W-1:0] mask,
    // Decoded command
    sdcr_cmd_if.producer out
);
    localparam int W = 5 + sdcr_pkg::BANK_W + sdcr_pkg::ROW_W
        + sdcr_pkg::MASK_W;

    typedef struct packed {
        logic [sdcr_pkg::SYNC_STAGES-1:0][W-1:0] pipe;
        logic cke_prev;
    } sdcr_dec_state_type;

    sdcr_dec_state_type s_q, s_d;
    logic [W-1:0] raw, cur;

    assign raw = {cs_n, ras_n, cas_n, we_n, cke, bank, addr, mask};

    always_comb begin
        s_d = s_q;
        s_d.pipe[0] = raw;
        s_d.pipe[1] = s_q.pipe[0];
        s_d.pipe[2] = s_q.pipe[1];
        s_d.cke_prev = cur[W-5];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Third stage feeds the decoder
    assign cur = s_q.pipe[2];

    always_comb begin
        logic [2:0] code;
        code = cur[W-2 -: 3];
        out.cmd = sdcr_pkg::DEC_NONE;
        out.bank = cur[sdcr_pkg::MASK_W+sdcr_pkg::ROW_W +: sdcr_pkg::BANK_W];
        out.addr = cur[sdcr_pkg::MASK_W +: sdcr_pkg::ROW_W];
        out.mask = cur[sdcr_pkg::MASK_W-1:0];
        out.cke_now = cur[W-5];
        if (!cur[W-1] && s_q.cke_prev) begin
            if (code == sdcr_pkg::CMD_OPEN) begin
                out.cmd = sdcr_pkg::DEC_OPEN;
            end else if (code == sdcr_pkg::CMD_CLOSE) begin
                out.cmd = out.addr[sdcr_pkg::AUTO_CLOSE_BIT] ?
                    sdcr_pkg::DEC_CLOSE_ALL : sdcr_pkg::DEC_CLOSE;
            end else if (code == sdcr_pkg::CMD_READ) begin
                out.cmd = sdcr_pkg::DEC_READ;
            end else if (code == sdcr_pkg::CMD_WRITE) begin
                out.cmd = sdcr_pkg::DEC_WRITE;
            end else if (code == sdcr_pkg::CMD_STOP) begin
                out.cmd = sdcr_pkg::DEC_STOP;
            end else if (code == sdcr_pkg::CMD_REFRESH) begin
                out.cmd = sdcr_pkg::DEC_REFRESH;
            end
        end
    end
endmodule // sdcr_decode

// ===== tb/sdcr_ctl.sv
// Controller model driving the command pins
module sdcr_ctl (
    // Clock
    input wire logic clk,
    // Command pins
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic cke,
    output logic [1:0] bank,
    output logic [11:0] addr,
    output logic [1:0] dqm
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cs_n, ras_n, cas_n, we_n, cke} = 5'h1F;
        bank = 2'h0;
        addr = 12'h000;
        dqm = 2'h0;
    end
    // One command, then no-operation with other field values
    task automatic cmd(input logic s, input logic [2:0] c,
                       input logic [1:0] b, input logic [11:0] a);
        @(posedge clk);
        #2;
        cs_n = s;
        {ras_n, cas_n, we_n} = c;
        bank = b;
        addr = a;
        @(posedge clk);
        #2;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        bank = ~b;
        addr = ~a;
        repeat (6) @(posedge clk);
    endtask
endmodule // sdcr_ctl

// ===== tb/sdcr_core_monitor.sv
// Port checker bound to the core
module sdcr_mon (
    // Clock, reset, command pins and mode settings
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [1:0] bank,
    input wire logic [11:0] addr,
    input wire logic [1:0] dqm,
    input wire logic [2:0] burst_len,
    input wire logic [2:0] cas_latency,
    // Outputs
    input wire logic [15:0] dq_oe,
    input wire logic array_rd,
    input wire logic [1:0] array_bank,
    input wire logic [7:0] array_col,
    input wire logic [3:0] bank_open,
    input wire logic auto_close_req
);
    logic cke_q;
    logic live;
    logic pg;
    logic [2:0] c;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= cke;
        end
    end
    assign c = {ras_n, cas_n, we_n};
    assign live = !cs_n && cke && cke_q;
    assign pg = burst_len == sdcr_pkg::BL_PAGE;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_open_bank: assert property (
        live && c == sdcr_pkg::CMD_OPEN && bank == 2'h0
        |-> ##[3:5] bank_open[0]) else $error("bank zero not opened");
    a_close_one: assert property (
        live && c == sdcr_pkg::CMD_CLOSE && !addr[10] && bank == 2'h0
        |-> ##[3:5] !bank_open[0]) else $error("bank zero not closed");
    a_close_all: assert property (
        live && c == sdcr_pkg::CMD_CLOSE && addr[10]
        |-> ##[3:5] bank_open == 4'h0) else $error("banks left open");
    a_read_open: assert property (
        array_rd |-> bank_open[array_bank]) else $error("idle bank read");
    a_auto_req: assert property (
        live && c == sdcr_pkg::CMD_READ && addr[10]
        |-> ##[3:5] auto_close_req) else $error("auto close missed");
    a_byte_pair: assert property (
        dq_oe[7:0] inside {8'h00, 8'hFF} && dq_oe[15:8] inside {8'h00, 8'hFF})
        else $error("byte enable split");
    a_mask_lat: assert property (
        dq_oe[8] |-> !$past(dqm[1], 7)) else $error("masked byte driven");
    a_lat_two: assert property (
        !pg && cas_latency == 3'h2 && |dq_oe |-> $past(array_rd, 2))
        else $error("data timing wrong at latency two");
    a_lat_three: assert property (
        !pg && cas_latency == 3'h3 && |dq_oe |-> $past(array_rd, 3))
        else $error("data timing wrong at latency three");
    a_page_step: assert property (
        array_rd && $past(array_rd) && pg
        |-> array_col == $past(array_col) + 8'h01)
        else $error("page column did not step");
endmodule // sdcr_mon
bind sdcr_core sdcr_mon sdcr_mon_inst (.clk(clk), .reset_n(reset_n),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
    .bank(bank), .addr(addr), .dqm(dqm), .burst_len(burst_len),
    .cas_latency(cas_latency), .dq_oe(dq_oe), .array_rd(array_rd),
    .array_bank(array_bank), .array_col(array_col),
    .bank_open(bank_open), .auto_close_req(auto_close_req));

// ===== tb/sdcr_core_tb.sv
// Self-checking bench of the command, bank and read core
module sdcr_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, cs_n, ras_n, cas_n, we_n, cke, hit;
    logic burst_interleave, array_rd, illegal_access, auto_close_req;
    logic [1:0] bank, dqm, power_state, cur_b, array_bank;
    logic [2:0] burst_len, cas_latency;
    logic [11:0] addr, array_row;
    logic [15:0] array_rdata, dq_o, dq_oe;
    logic [7:0] array_col, st;
    logic [3:0] bank_open;
    logic [7:0] cols[$];
    logic [11:0] rows[4];
    int n_errors, samples_checked, n_oe, n_hi;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    sdcr_core #(.CAS_LAT(2)) sdcr_core_inst (.clk(clk), .reset_n(reset_n),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
        .bank(bank), .addr(addr), .dqm(dqm), .burst_len(burst_len),
        .burst_interleave(burst_interleave), .cas_latency(cas_latency),
        .array_rdata(array_rdata), .dq_o(dq_o), .dq_oe(dq_oe),
        .array_rd(array_rd), .array_bank(array_bank),
        .array_row(array_row), .array_col(array_col),
        .bank_open(bank_open), .illegal_access(illegal_access),
        .auto_close_req(auto_close_req), .power_state(power_state));
    sdcr_ctl sdcr_ctl_inst (.clk(clk), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .cke(cke), .bank(bank), .addr(addr),
        .dqm(dqm));
    function automatic logic [7:0] ecol(input logic [7:0] s, input int i);
        logic [7:0] m;
        m = (burst_len == sdcr_pkg::BL_PAGE) ? 8'hFF : 8'((1 << burst_len) - 1);
        if (burst_interleave) return (s & ~m) | ((s ^ 8'(i)) & m);
        return (s & ~m) | ((s + 8'(i)) & m);
    endfunction
    function automatic logic [15:0] dat(input logic [1:0] b,
                                        input logic [7:0] c);
        return {6'h2A, b, c};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        samples_checked++;
        if (e !== s) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic c(input logic s, input logic [2:0] k,
                     input logic [1:0] b, input logic [11:0] a);
        sdcr_ctl_inst.cmd(s, k, b, a);
    endtask
    // Array model and output watcher
    always @(posedge clk) begin
        array_rdata <= array_rd ? dat(array_bank, array_col) : ~array_rdata;
        if (array_rd === 1'b1) cols.push_back(array_col);
        if (array_rd === 1'b1) chk("row", rows[array_bank], array_row);
        if (illegal_access === 1'b1) hit = 1'b1;
        if (dq_oe[0] === 1'b1 && burst_len != sdcr_pkg::BL_PAGE)
            chk("dq", dat(cur_b, ecol(st, n_oe)) & dq_oe,
                dq_o & dq_oe);
        if (dq_oe[8] === 1'b1) n_hi++;
        if (dq_oe !== 16'h0000) n_oe++;
    end
    task automatic rd(input logic [2:0] bl, input logic il, input int stop);
        #2;
        cur_b = {1'($urandom), 1'b0};
        st = (stop > 0) ? 8'hFC : 8'($urandom);
        burst_len = bl;
        burst_interleave = il;
        cas_latency = 3'h2 + 3'($urandom % 2);
        cols.delete();
        n_oe = 0;
        n_hi = 0;
        c(1'b0, sdcr_pkg::CMD_READ, cur_b, {4'h0, st});
        if (stop > 0) begin
            repeat (stop) @(posedge clk);
            #2 sdcr_ctl_inst.cke = 1'b0;
            repeat (6) @(posedge clk);
            chk("suspend", 2'h1, power_state);
            #2 sdcr_ctl_inst.cke = 1'b1;
            c(1'b0, sdcr_pkg::CMD_STOP, 2'h0, 12'h000);
        end
        repeat (24) @(posedge clk);
        chk("oe idle", 0, dq_oe);
        if (stop == 0) chk("words", 1 << bl, n_oe);
        if (stop == 0) chk("reads", 1 << bl, cols.size());
        foreach (cols[k]) chk("col", ecol(st, k), cols[k]);
    endtask
    initial begin
        #1000000;
        n_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hDBC09D8A));
        reset_n = 1'b0;
        {burst_len, burst_interleave, cas_latency} = 7'h02;
        {array_rdata, hit, cur_b, st} = 27'h0;
        repeat (16) @(posedge clk);
        #2 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        rows[0] = 12'($urandom);
        rows[2] = 12'($urandom);
        c(1'b0, sdcr_pkg::CMD_OPEN, 2'h0, rows[0]);
        c(1'b0, sdcr_pkg::CMD_OPEN, 2'h2, rows[2]);
        c(1'b1, sdcr_pkg::CMD_OPEN, 2'h1, 12'h000);
        chk("open", 4'h5, bank_open);
        for (int i = 0; i < 8; i++) rd(3'(i % 4), 1'(i / 4), 0);
        #2 sdcr_ctl_inst.dqm = 2'h2;
        rd(sdcr_pkg::BL_8, 1'b0, 0);
        chk("masked", 0, n_hi);
        #2 cas_latency = 3'h3;
        cur_b = 2'h0;
        st = 8'h00;
        n_oe = 0;
        c(1'b0, sdcr_pkg::CMD_READ, 2'h0, 12'h000);
        #2 sdcr_ctl_inst.dqm = 2'h3;
        @(posedge clk);
        c(1'b0, sdcr_pkg::CMD_WRITE, 2'h0, 12'h000);
        repeat (16) @(posedge clk);
        chk("cut", 6, n_oe);
        #2 sdcr_ctl_inst.dqm = 2'h0;
        rd(sdcr_pkg::BL_PAGE, 1'b0, 4);
        hit = 1'b0;
        cols.delete();
        c(1'b0, sdcr_pkg::CMD_READ, 2'h1, 12'h000);
        chk("illegal", 1, hit);
        chk("no read", 0, cols.size());
        c(1'b0, sdcr_pkg::CMD_READ, 2'h0, 12'h400);
        c(1'b0, sdcr_pkg::CMD_CLOSE, 2'h0, 12'h000);
        chk("close one", 4'h4, bank_open);
        c(1'b0, sdcr_pkg::CMD_CLOSE, 2'($urandom), 12'h400);
        chk("close all", 0, bank_open);
        fork
            c(1'b0, sdcr_pkg::CMD_REFRESH, 2'h0, 12'h000);
            begin
                @(posedge clk);
                #2 sdcr_ctl_inst.cke = 1'b0;
            end
        join
        chk("self refresh", 2'h3, power_state);
        #2 sdcr_ctl_inst.cke = 1'b1;
        repeat (6) @(posedge clk);
        chk("run", 2'h0, power_state);
        #2 sdcr_ctl_inst.cke = 1'b0;
        repeat (6) @(posedge clk);
        chk("power down", 2'h2, power_state);
        #2 sdcr_ctl_inst.cke = 1'b1;
        print_verdict();
    end
endmodule // sdcr_core_tb
